/* File: hdl/hbp_dev_end.sv */
// Framer receive back-plane serializer and its slot-word FIFO.
// Assumes the link clock and sync arrive asynchronously on pins.
`timescale 1ns/1ps

// ****************************************
// Slot-word FIFO
// ****************************************
module hbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready_o = cnt_r != FULL_CNT;
  assign out_valid_o = cnt_r != '0;
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == LAST_IDX) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == LAST_IDX) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

module hbp_dev_end
  import hbp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mux_en_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WORD_W-1:0] wr_data_i,
  output logic aligned_o,
  output logic underrun_o,
  hbp_link_if.dev_mp link
);
  // ****************************************
  // Mode decode
  // ****************************************
  logic m8;
  logic mx;
  logic active;
  assign m8 = !mux_en_i && (mode_sel_i == SEL_8M);
  assign mx = mux_en_i && (mode_sel_i == SEL_MX);
  assign active = m8 || mx;

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  logic sync_s1_r;
  logic sync_s2_r;
  logic sync_last_r;
  logic rise;
  logic sync_new;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= link.sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      sync_s1_r <= link.sync;
      sync_s2_r <= sync_s1_r;
    end
  end

  assign rise = sclk_s2_r && !sclk_s3_r;
  assign sync_new = rise && sync_s2_r && !sync_last_r;

  // Sync level as seen at the previous rising edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_last_r <= 1'b0;
    end else if (rise) begin
      sync_last_r <= sync_s2_r;
    end
  end

  // ****************************************
  // Frame position and bit launch
  // ****************************************
  logic aligned_r;
  logic [1:0] div_r;
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  logic [POS_W-1:0] last_pos;
  logic launch;

  assign last_pos = m8 ? LAST_8M : LAST_MX;
  assign launch = active && rise && (sync_new || (aligned_r && (mx || div_r == 2'd0)));
  assign pos_nxt = sync_new ? '0 : ((pos_r == last_pos) ? '0 : pos_r + 1'b1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aligned_r <= 1'b0;
    end else if (!active) begin
      aligned_r <= 1'b0;
    end else if (sync_new) begin
      aligned_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 2'd0;
    end else if (sync_new) begin
      div_r <= 2'd1;
    end else if (rise && m8) begin
      div_r <= div_r + 2'd1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pos_r <= '0;
    end else if (launch) begin
      pos_r <= pos_nxt;
    end
  end

  // ****************************************
  // Slot word fetch
  // ****************************************
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic [WORD_W-1:0] cur_r;
  logic [WORD_W-1:0] src;
  logic [POS_W-1:0] mx_off;
  logic load;
  logic pop;

  hbp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  assign mx_off = pos_nxt - MX_F_BITS;
  // New slot word at each payload octet (8.192) or slot group (mux)
  assign load = m8 ? (pos_nxt[2:0] == 3'd0 && pos_nxt[4:3] != 2'd0)
                   : (pos_nxt >= MX_F_BITS && mx_off[5:0] == 6'd0);
  assign pop = launch && load && fifo_valid;

  // Framing octet peeks the head word; the slot-0 pop comes after it
  always_comb begin
    if (load || pos_nxt < MX_F_BITS) begin
      src = fifo_valid ? fifo_data : '0;
    end else begin
      src = cur_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_r <= '0;
    end else if (launch && load) begin
      cur_r <= src;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      underrun_o <= 1'b0;
    end else begin
      underrun_o <= launch && load && !fifo_valid;
    end
  end

  // ****************************************
  // Bit selection
  // ****************************************
  logic bit_val;
  logic [1:0] ch;
  logic [2:0] nb;

  assign ch = mx_off[2:1];
  assign nb = mx_off[5:3];

  always_comb begin
    bit_val = 1'b0;
    if (m8) begin
      if (pos_nxt == '0) begin
        bit_val = src[F_LSB];
      end else if (pos_nxt[4:3] == 2'd0) begin
        bit_val = 1'b0;
      end else begin
        bit_val = src[DATA_LSB + {2'b00, ~pos_nxt[2:0]}];
      end
    end else if (pos_nxt < MX_F_BITS) begin
      bit_val = src[F_LSB + pos_nxt[2:1]];
    end else if (mx_off[0] && nb[2]) begin
      bit_val = src[SIG_LSB + {ch, ~nb[1:0]}];
    end else begin
      bit_val = src[DATA_LSB + {ch, ~nb}];
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  logic sdata_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdata_r <= 1'b0;
    end else if (!active) begin
      sdata_r <= 1'b0;
    end else if (launch) begin
      sdata_r <= bit_val;
    end
  end

  assign link.sdata = sdata_r;
  assign aligned_o = aligned_r;
endmodule

/* File: hdl/hbp_pkg.sv */
// Constants shared by both ends of the receive high-speed back-plane link.
// Assumes a 125 MHz system clock on each end.
package hbp_pkg;
  // ****************************************
  // Clock and link rates
  // ****************************************
  localparam int CLK_KHZ = 125000;
  localparam int LINK_8M_KHZ = 8192;
  localparam int LINK_MX_KHZ = 12352;
  // Half periods of the terminal clock, rounded down
  localparam int HALF_8M = CLK_KHZ / (2 * LINK_8M_KHZ);
  localparam int HALF_MX = CLK_KHZ / (2 * LINK_MX_KHZ);
  localparam int EDGES_PER_BIT = 4;

  // ****************************************
  // Mode selection
  // ****************************************
  localparam logic [1:0] SEL_8M = 2'b11;
  localparam logic [1:0] SEL_MX = 2'b00;

  // ****************************************
  // Frame geometry
  // ****************************************
  localparam int POS_W = 11;
  localparam logic [POS_W-1:0] LAST_8M = 11'h0ff;
  localparam logic [POS_W-1:0] LAST_MX = 11'h607;
  localparam logic [POS_W-1:0] MX_F_BITS = 11'h008;

  // ****************************************
  // Slot word: four channels of one T1 slot
  // ****************************************
  localparam int NCH = 4;
  localparam int DATA_LSB = 0;
  localparam int SIG_LSB = 32;
  localparam int F_LSB = 48;
  localparam int WORD_W = 52;
  localparam int FIFO_DEPTH = 4;
endpackage

/* File: hdl/hbp_link_if.sv */
// Back-plane link between the framer receive end and terminal equipment.
// The bench resolves nothing here: every wire has one driver.
`timescale 1ns/1ps
interface hbp_link_if;
  logic sclk;
  logic sync;
  logic sdata;
  modport dev_mp (
    input sclk,
    input sync,
    output sdata
  );
  modport te_mp (
    output sclk,
    output sync,
    input sdata
  );
endinterface

/* File: hdl/hbp_te_end.sv */
// Terminal equipment end: makes the serial clock and frame sync,
// samples the serial data. Assumes the far end launches on rising edges.
`timescale 1ns/1ps
module hbp_te_end
  import hbp_pkg::*;
#(
  parameter int HALF_SLOW = HALF_8M,
  parameter int HALF_FAST = HALF_MX
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic mux_en_i,
  output logic bit_o,
  output logic [POS_W-1:0] bit_pos_o,
  output logic bit_valid_o,
  hbp_link_if.te_mp link
);
  // ****************************************
  // Clock divider
  // ****************************************
  logic [7:0] div_r;
  logic [7:0] half_m1;
  logic sclk_r;
  logic tick;
  logic rise_evt;
  logic fall_evt;

  assign half_m1 = mux_en_i ? 8'(HALF_FAST - 1) : 8'(HALF_SLOW - 1);
  assign tick = enable_i && (div_r >= half_m1);
  assign rise_evt = tick && !sclk_r;
  assign fall_evt = tick && sclk_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 8'h00;
      sclk_r <= 1'b0;
    end else if (!enable_i) begin
      div_r <= 8'h00;
      sclk_r <= 1'b0;
    end else if (tick) begin
      div_r <= 8'h00;
      sclk_r <= !sclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ****************************************
  // Edge phase and frame sync
  // ****************************************
  logic [1:0] sub_r;
  logic sync_r;
  logic [POS_W-1:0] bitcnt_r;
  logic [POS_W-1:0] last_pos;

  assign last_pos = mux_en_i ? LAST_MX : LAST_8M;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sub_r <= 2'd0;
    end else if (!enable_i) begin
      sub_r <= 2'd0;
    end else if (rise_evt) begin
      sub_r <= mux_en_i ? 2'd0 : sub_r + 2'd1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_r <= 1'b0;
    end else if (!enable_i) begin
      sync_r <= 1'b0;
    end else if (rise_evt) begin
      sync_r <= (sub_r == 2'd0) && (bitcnt_r == '0);
    end
  end

  // ****************************************
  // Data sampling
  // ****************************************
  logic sd_s1_r;
  logic sd_s2_r;
  logic [1:0] samp_d_r;
  logic samp;

  // Falling edge of the launching clock period only
  assign samp = fall_evt && (mux_en_i || sub_r == 2'd1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sd_s1_r <= 1'b0;
      sd_s2_r <= 1'b0;
      samp_d_r <= 2'b00;
    end else begin
      sd_s1_r <= link.sdata;
      sd_s2_r <= sd_s1_r;
      // Delay matches the synchroniser so the pin is read at the fall
      samp_d_r <= {samp_d_r[0], samp};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_o <= 1'b0;
      bit_pos_o <= '0;
      bit_valid_o <= 1'b0;
      bitcnt_r <= '0;
    end else begin
      bit_valid_o <= samp_d_r[1] && enable_i;
      if (!enable_i) begin
        bitcnt_r <= '0;
      end else if (samp_d_r[1]) begin
        bit_o <= sd_s2_r;
        bit_pos_o <= bitcnt_r;
        bitcnt_r <= (bitcnt_r == last_pos) ? '0 : bitcnt_r + 1'b1;
      end
    end
  end

  assign link.sclk = sclk_r;
  assign link.sync = sync_r;
endmodule

/* File: tb/hbp_chk.sv */
// Checker on the link wires between the two ends.
// Assumes sclk and sync come from the terminal end's clk_i flops.
`timescale 1ns/1ps
module hbp_chk
  import hbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mux_en_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic sclk,
  input wire logic sync,
  input wire logic sdata
);
  logic sclk_r;
  logic sync_r;
  logic sdata_r;
  logic seen_r;
  logic [3:0] gap_r;
  logic [11:0] rises_r;
  logic rise;
  logic srise;
  logic mode8;
  logic valid_mode;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  assign rise = sclk && !sclk_r;
  assign srise = sync && !sync_r;
  assign mode8 = !mux_en_i && mode_sel_i == SEL_8M;
  assign valid_mode = mode8 || (mux_en_i && mode_sel_i == SEL_MX);
  // *****
  // Edge history
  // *****
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_r <= 1'b0;
      sync_r <= 1'b0;
      sdata_r <= 1'b0;
    end else begin
      sclk_r <= sclk;
      sync_r <= sync;
      sdata_r <= sdata;
    end
  end
  // Serial clock rises since the last data change
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_r <= 4'h0;
    end else if (sdata != sdata_r) begin
      gap_r <= {3'h0, rise};
    end else if (rise && gap_r != 4'hf) begin
      gap_r <= gap_r + 4'h1;
    end
  end
  // Serial clock rises in the current frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rises_r <= 12'h000;
      seen_r <= 1'b0;
    end else begin
      seen_r <= seen_r | srise;
      if (rise) begin
        rises_r <= srise ? 12'h001 : rises_r + 12'h001;
      end
    end
  end
  // *****
  // Properties
  // *****
  sclk_half_a: assert property ($changed(sclk) |=> $stable(sclk)[*4])
    else $error("sclk half period too short");
  sync_on_rise_a: assert property ($rose(sync) |-> $rose(sclk))
    else $error("sync rose off a clock rise");
  sync_width_a: assert property ($rose(sync) |-> sync[*8] ##[3:7] $fell(sync))
    else $error("sync width wrong");
  sync_drop_a: assert property ($fell(sync) |-> $rose(sclk))
    else $error("sync fell off a clock rise");
  idle_zero_a: assert property ((!valid_mode)[*3] |-> !sdata)
    else $error("data driven in idle mode");
  launch_edge_a: assert property ($changed(sdata) && valid_mode
    |-> $past(rise, 3) || $past(rise, 4) || $past(rise, 5))
    else $error("data changed away from a clock rise");
  launch_gap_a: assert property (mode8 && $changed(sdata) |-> gap_r >= 4'h4)
    else $error("data changed before fourth rise");
  // Clock rises per frame: one per bit muxed, four per bit otherwise
  frame_len_a: assert property (srise && seen_r |->
    rises_r == (mux_en_i ? 12'(LAST_MX) + 12'h001 :
    (12'(LAST_8M) + 12'h001) * 12'(EDGES_PER_BIT)))
    else $error("frame length wrong");
  cover property ($rose(sync) && mode8);
  cover property ($rose(sync) && mux_en_i);
  cover property (mode8 && $changed(sdata));
endmodule

/* File: tb/testbench.sv */
// Bench joining both ends; the sampled stream is compared bit by bit.
// Assumes the terminal end reports each bit with its frame position.
`timescale 1ns/1ps
module testbench;
  import hbp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mux_en_i = 1'b0;
  logic [1:0] mode_sel_i = 2'h1;
  logic wr_valid_i = 1'b0;
  logic [WORD_W-1:0] wr_data_i = '0;
  logic enable_i = 1'b0;
  logic wr_ready_o, aligned_o, underrun_o, bit_o, bit_valid_o;
  logic [POS_W-1:0] bit_pos_o;
  logic [POS_W-1:0] maxpos = '0;
  int errors = 0, compares = 0, cycles = 0, wnum = 0, frame = -1;
  bit feed = 1'b0, mon = 1'b0, urun = 1'b0;
  hbp_link_if link ();
  hbp_dev_end #(.DEPTH(FIFO_DEPTH)) u_hbp_dev_end (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mux_en_i(mux_en_i), .mode_sel_i(mode_sel_i), .wr_valid_i(wr_valid_i),
    .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i), .aligned_o(aligned_o),
    .underrun_o(underrun_o), .link(link.dev_mp));
  hbp_te_end u_hbp_te_end (.clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
    .mux_en_i(mux_en_i), .bit_o(bit_o), .bit_pos_o(bit_pos_o),
    .bit_valid_o(bit_valid_o), .link(link.te_mp));
  hbp_chk u_hbp_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .mux_en_i(mux_en_i),
    .mode_sel_i(mode_sel_i), .sclk(link.sclk), .sync(link.sync), .sdata(link.sdata));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // *****
  // Helpers
  // *****
  function automatic logic [WORD_W-1:0] wd(input int n);
    logic [31:0] h;
    h = n * 32'h9e3779b1 + 32'h5a;
    return {h[27:24] ^ 4'(n), h[31:16] ^ 16'(n * 7), h ^ 32'(n)};
  endfunction
  function automatic logic exp_bit(input logic mx, input int f, input int p);
    int o, s, r, n, ch;
    logic [WORD_W-1:0] w;
    o = p / 8;
    s = mx ? (p - 8) / 64 : 3 * (o / 4) + o % 4 - 1;
    w = wd(24 * f + ((mx && p < 8) || o == 0 ? 0 : s));
    if (!mx) begin
      if (o % 4 == 0) begin
        return (p == 0) ? w[F_LSB] : 1'b0;
      end
      return w[DATA_LSB + 7 - p % 8];
    end
    if (p < 8) begin
      return w[F_LSB + p / 2];
    end
    r = (p - 8) % 64;
    n = r / 8;
    ch = (r % 8) / 2;
    if (r % 2 == 1 && n >= 4) begin
      return w[SIG_LSB + 4 * ch + 7 - n];
    end
    return w[DATA_LSB + 8 * ch + 7 - n];
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // *****
  // Drivers and monitor
  // *****
  always @(negedge clk_i) begin
    wr_valid_i <= feed;
    wr_data_i <= wd(wnum);
  end
  always @(posedge clk_i) begin
    cycles++;
    if (wr_valid_i && wr_ready_o) wnum <= wnum + 1;
    if (underrun_o === 1'b1) urun <= 1'b1;
    if (mon && bit_valid_o === 1'b1) begin
      if (bit_pos_o == '0) frame = frame + 1;
      if (bit_pos_o > maxpos) maxpos = bit_pos_o;
      if (frame >= 0) check("bit_o", bit_o, exp_bit(mux_en_i, frame, int'(bit_pos_o)));
    end
    if (cycles == 90000) begin
      errors++;
      finish_test();
    end
  end
  // *****
  // Scenarios
  // *****
  task automatic start(input logic mx, input logic [1:0] sel);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    {enable_i, feed, mon} = 3'h0;
    repeat (4) @(negedge clk_i);
    {mux_en_i, mode_sel_i} = {mx, sel};
    {wnum, frame, maxpos, urun} = {32'h0, -32'sh1, 11'h0, 1'b0};
    rst_n_i = 1'b1;
    feed = 1'b1;
    for (int t = 0; t < 50 && wnum < 4; t++) @(negedge clk_i);
    repeat (4) @(negedge clk_i);
    check("fill", wnum, 4);
    check("wr_ready_o", wr_ready_o, 1'b0);
    check("aligned_o", aligned_o, 1'b0);
    enable_i = 1'b1;
  endtask
  task automatic run_idle(input logic mx, input logic [1:0] sel);
    start(mx, sel);
    repeat (2000) @(negedge clk_i);
    check("pops", wnum, 4);
    check("aligned_o", aligned_o, 1'b0);
    check("sdata", link.sdata, 1'b0);
  endtask
  task automatic run_mode(input logic mx, input logic [1:0] sel, input logic [POS_W-1:0] lastp);
    start(mx, sel);
    mon = 1'b1;
    for (int t = 0; t < 40000 && frame < 2; t++) @(negedge clk_i);
    check("frames", frame, 2);
    check("aligned_o", aligned_o, 1'b1);
    check("last_pos", maxpos, lastp);
    {mon, feed} = 2'h0;
    for (int t = 0; t < 6000 && !urun; t++) @(negedge clk_i);
    check("underrun_o", urun, 1'b1);
  endtask
  initial begin
    run_idle(1'b0, 2'h1);
    run_idle(1'b1, SEL_8M);
    run_mode(1'b0, SEL_8M, LAST_8M);
    run_mode(1'b1, SEL_MX, LAST_MX);
    finish_test();
  end
endmodule
